// ### hw/tmon_pkg.sv
// shared constants and carrier types of the temperature monitor register bank
package tmon_pkg;
  // ==========================================================================
  // command byte codes of the register bank
  localparam logic [7:0] CMD_CFG1  = 8'h41;
  localparam logic [7:0] CMD_CFG2  = 8'h42;
  localparam logic [7:0] CMD_CFG3  = 8'h43;
  localparam logic [7:0] CMD_STAT1 = 8'h44;
  localparam logic [7:0] CMD_STAT2 = 8'h45;
  localparam logic [7:0] CMD_STAT3 = 8'h46;

  // ==========================================================================
  // reset values and field layout
  localparam logic [7:0] REG_POR_VAL    = 8'h00;
  localparam logic [7:0] UNMAPPED_VAL   = 8'h00;
  localparam int         CFG1_STBY_BIT  = 7;
  localparam int         CFG1_SRST_BIT  = 6;
  localparam int         CFG1_TODIS_BIT = 5;
  localparam int         CFG1_FAST_BIT  = 4;
  localparam int         CFG1_RCAN_BIT  = 3;
  // writable bits; reset bit is a strobe and never stored
  localparam logic [7:0] CFG1_WMASK     = 8'hB8;
  localparam logic [7:0] CFG2_WMASK     = 8'h4F;
  localparam logic [7:0] CFG3_WMASK     = 8'h09;
  localparam int         STAT1_LOC_BIT  = 6;
  localparam int         CRIT_CH1_BIT   = 0;
  localparam int         CRIT_CH4_BIT   = 3;
  localparam int         STAT3_FLT_LSB  = 1;
  localparam logic [7:0] STAT3_LATE_ONE = 8'h60;

  // ==========================================================================
  // counts and hysteresis
  localparam int         NUM_REMOTE     = 4;
  localparam int         NUM_CRIT       = 2;
  localparam logic [7:0] HYST_DEG       = 8'h04;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic [7:0] temp;
    logic [7:0] limit;
  } tmon_crit_meas_t;

  typedef struct packed {
    logic standby;
    logic timeout_en;
    logic fast_ch1;
    logic res_cancel;
  } tmon_ctrl_t;
endpackage : tmon_pkg

// ### hw/tmon_sync.sv
// two-stage synchroniser for asynchronous level inputs
`timescale 1ns/10ps
module tmon_sync
  import tmon_pkg::*;
#(
  parameter int WIDTH = 4
)(
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  typedef struct packed {
    logic [WIDTH-1:0] ff1;
    logic [WIDTH-1:0] ff2;
  } tmon_sync_state_t;

  tmon_sync_state_t state_reg;
  tmon_sync_state_t state_next;

  always_comb
  begin
    state_next     = state_reg;
    state_next.ff1 = async_i;
    state_next.ff2 = state_reg.ff1;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign sync_o = state_reg.ff2;
endmodule : tmon_sync

// ### hw/tmon_crit_hyst.sv
// critical-temperature latch of one channel with fixed hysteresis
`timescale 1ns/10ps
module tmon_crit_hyst
  import tmon_pkg::*;
(
  input  wire logic            clk_sys_i,
  input  wire logic            rst_i,
  input  wire logic            soft_rst_i,
  input  wire logic            conv_done_i,
  input  wire tmon_crit_meas_t meas_i,
  output logic                 over_o,
  output logic                 active_o
);
  typedef struct packed {
    logic active;
  } tmon_hyst_state_t;

  tmon_hyst_state_t state_reg;
  tmon_hyst_state_t state_next;
  logic             above;
  logic             below_hyst;

  // nine bits so temperature plus the hysteresis never wraps
  assign above      = meas_i.temp > meas_i.limit;
  assign below_hyst = ({1'b0, meas_i.temp} + {1'b0, HYST_DEG}) < {1'b0, meas_i.limit};
  assign over_o     = conv_done_i & above;

  always_comb
  begin
    state_next = state_reg;
    if (soft_rst_i)
    begin
      state_next.active = 1'b0;
    end
    else if (conv_done_i && above)
    begin
      state_next.active = 1'b1;
    end
    else if (conv_done_i && below_hyst)
    begin
      state_next.active = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign active_o = state_reg.active;
endmodule : tmon_crit_hyst

// ### hw/tmon_regs.sv
// configuration and status register bank of the five-channel temperature monitor
`timescale 1ns/10ps

// Overview of operation
// - config 1 bit 7 set holds the device in standby, no conversions.
// - writing 1 to config 1 bit 6 resets all registers but status 3; bit self-clears.
// - config 1 bit 5 low enables bus timeout, high disables it.
// - config 1 bit 4 makes channel 1 convert more often.
// - config 1 bit 3 enables series-resistance cancellation on channel 1.
// - config 2 bit 6 keeps local exceedance off the warning output.
// - config 2 bits 3..0 mask warning output from remote channels 4..1.
// - config 3 bits 3 and 0 mask channels 4 and 1 from critical output.
// - status 1 bit 6 sets when local temperature exceeds its warning limit.
// - status 1 bits 3..0 set when remote channels 4..1 exceed warning limit.
// - status 2 bits 3 and 0 set when channels 4 and 1 exceed critical limit.
// - status 3 bits 4..1 show open or supply-tied diode on channels 4..1.
// - status 3 bits 6 and 5 read 0 just after power-on, then 1.
// - reading status 1 clears it; persisting conditions set again next conversion.
// - warning output follows unmasked status 1; read or alert response clears.
// - status 2 clears only on its read or a soft reset; that read keeps critical output.
// - critical output holds until temperature falls below limit minus 4 degrees.
module tmon_regs
  import tmon_pkg::*;
(
  input  wire logic                             clk_sys_i,
  input  wire logic                             rst_i,
  // command-byte register port
  input  wire logic [7:0]                       reg_addr_i,
  input  wire logic                             reg_wr_i,
  input  wire logic [7:0]                       reg_wdata_i,
  input  wire logic                             reg_rd_i,
  output logic      [7:0]                       reg_rdata_o,
  output logic                                  reg_rvalid_o,
  // alert response address cycle completed
  input  wire logic                             ara_ok_i,
  // conversion results, same clock domain
  input  wire logic                             conv_done_i,
  input  wire logic [NUM_REMOTE:0]              warn_exceed_i,
  input  wire tmon_crit_meas_t [NUM_CRIT-1:0]   crit_meas_i,
  // diode fault levels from the analog front end
  input  wire logic [NUM_REMOTE-1:0]            diode_fault_i,
  // control outputs
  output tmon_ctrl_t                            ctrl_o,
  output logic                                  soft_reset_o,
  // open-drain outputs, enable high while pulling low
  output logic                                  alert_out_o,
  output logic                                  alert_oe_o,
  output logic                                  critical_temp_out_o,
  output logic                                  critical_temp_oe_o
);
  // ==========================================================================
  // state
  typedef struct packed {
    logic [7:0] cfg1;
    logic [7:0] cfg2;
    logic [7:0] cfg3;
    logic [7:0] stat1;
    logic [7:0] stat2;
    logic       alert;
    logic       por_done;
    logic [7:0] rdata;
    logic       rvalid;
  } tmon_regs_state_t;

  tmon_regs_state_t              state_reg;
  tmon_regs_state_t              state_next;
  logic [NUM_REMOTE-1:0]         fault_sync;
  logic [NUM_CRIT-1:0]           crit_over;
  logic [NUM_CRIT-1:0]           crit_active;
  logic [7:0]                    stat1_set;
  logic [7:0]                    stat2_set;
  logic [7:0]                    stat3_val;
  logic [7:0]                    warn_mask;
  logic [7:0]                    crit_mask;
  logic                          wr_cfg1;
  logic                          soft_rst;
  logic                          crit_any;
  logic [NUM_REMOTE-1:0]         remote_set;
  logic [NUM_REMOTE-1:0]         remote_mask;

  // true when the address equals the given command code
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] code);
    hit = (addr == code);
  endfunction : hit

  // register bit of critical latch idx; status 2 and config 3 share the layout
  function automatic logic [2:0] crit_pos(input int idx);
    if (idx == 0)
    begin
      crit_pos = 3'(CRIT_CH1_BIT);
    end
    else
    begin
      crit_pos = 3'(CRIT_CH4_BIT);
    end
  endfunction : crit_pos

  // ==========================================================================
  // synchronised fault inputs and critical latches
  tmon_sync #(
    .WIDTH (NUM_REMOTE)
  ) u_fault_sync (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .async_i   (diode_fault_i),
    .sync_o    (fault_sync)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CRIT; gi++)
    begin : g_crit
      tmon_crit_hyst u_hyst (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .soft_rst_i  (soft_rst),
        .conv_done_i (conv_done_i),
        .meas_i      (crit_meas_i[gi]),
        .over_o      (crit_over[gi]),
        .active_o    (crit_active[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // remote channel slices; remote channel r owns bit r of status 1 and config 2
  genvar gr;
  generate
    for (gr = 0; gr < NUM_REMOTE; gr++)
    begin : g_remote
      // the flag records the channel whether or not its pin contribution is masked
      assign remote_set[gr]  = conv_done_i & warn_exceed_i[gr];
      assign remote_mask[gr] = state_reg.cfg2[gr];
    end
  endgenerate

  // ==========================================================================
  // event and mask mapping
  assign wr_cfg1  = reg_wr_i && hit(reg_addr_i, CMD_CFG1);
  assign soft_rst = wr_cfg1 && reg_wdata_i[CFG1_SRST_BIT];

  always_comb
  begin
    stat1_set                = 8'h00;
    stat2_set                = 8'h00;
    stat3_val                = 8'h00;
    warn_mask                = 8'h00;
    crit_mask                = 8'h00;
    // status flags record every channel, masked or not
    if (conv_done_i)
    begin
      stat1_set[STAT1_LOC_BIT]      = warn_exceed_i[NUM_REMOTE];
    end
    stat1_set[NUM_REMOTE-1:0]       = remote_set;
    for (int c = 0; c < NUM_CRIT; c++)
    begin
      stat2_set[crit_pos(c)]        = crit_over[c];
      crit_mask[crit_pos(c)]        = state_reg.cfg3[crit_pos(c)];
    end
    stat3_val[STAT3_FLT_LSB +: NUM_REMOTE] = fault_sync;
    if (state_reg.por_done)
    begin
      stat3_val = stat3_val | STAT3_LATE_ONE;
    end
    warn_mask[STAT1_LOC_BIT]        = state_reg.cfg2[STAT1_LOC_BIT];
    warn_mask[NUM_REMOTE-1:0]       = remote_mask;
  end

  // ==========================================================================
  // register bank
  always_comb
  begin
    state_next          = state_reg;
    // the first clocked edge after power-on closes the power-on window
    state_next.por_done = 1'b1;
    state_next.rvalid   = 1'b0;

    // ------------------------------------------------------------------------
    // read path; read-clear below, set terms are applied after it so they win
    if (reg_rd_i)
    begin
      state_next.rvalid = 1'b1;
      if (hit(reg_addr_i, CMD_CFG1))
      begin
        state_next.rdata = state_reg.cfg1;
      end
      else if (hit(reg_addr_i, CMD_CFG2))
      begin
        state_next.rdata = state_reg.cfg2;
      end
      else if (hit(reg_addr_i, CMD_CFG3))
      begin
        state_next.rdata = state_reg.cfg3;
      end
      else if (hit(reg_addr_i, CMD_STAT1))
      begin
        state_next.rdata = state_reg.stat1;
        state_next.stat1 = 8'h00;
        state_next.alert = 1'b0;
      end
      else if (hit(reg_addr_i, CMD_STAT2))
      begin
        // critical pin is held by the latches, not by this register
        state_next.rdata = state_reg.stat2;
        state_next.stat2 = 8'h00;
      end
      else if (hit(reg_addr_i, CMD_STAT3))
      begin
        state_next.rdata = stat3_val;
      end
      else
      begin
        state_next.rdata = UNMAPPED_VAL;
      end
    end

    // an alert response releases only the pin; the status flags stay for the host
    if (ara_ok_i)
    begin
      state_next.alert = 1'b0;
    end

    // ------------------------------------------------------------------------
    // writes; status registers are read-only and ignore writes
    if (reg_wr_i)
    begin
      if (hit(reg_addr_i, CMD_CFG1))
      begin
        state_next.cfg1 = reg_wdata_i & CFG1_WMASK;
      end
      else if (hit(reg_addr_i, CMD_CFG2))
      begin
        state_next.cfg2 = reg_wdata_i & CFG2_WMASK;
      end
      else if (hit(reg_addr_i, CMD_CFG3))
      begin
        state_next.cfg3 = reg_wdata_i & CFG3_WMASK;
      end
    end

    // ------------------------------------------------------------------------
    // sticky sets win over a same-cycle read or alert-response clear
    state_next.stat1 = state_next.stat1 | stat1_set;
    state_next.stat2 = state_next.stat2 | stat2_set;
    if ((stat1_set & ~warn_mask) != 8'h00)
    begin
      state_next.alert = 1'b1;
    end

    // ------------------------------------------------------------------------
    // soft reset returns every register but status 3 to its power-on value
    // the power-on flag is left alone so status 3 keeps its late ones
    if (soft_rst)
    begin
      state_next.cfg1  = REG_POR_VAL;
      state_next.cfg2  = REG_POR_VAL;
      state_next.cfg3  = REG_POR_VAL;
      state_next.stat1 = REG_POR_VAL;
      state_next.stat2 = REG_POR_VAL;
      state_next.alert = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // outputs
  always_comb
  begin
    crit_any = 1'b0;
    // any unmasked latch holds the pin; a status 2 read never reaches here
    for (int c = 0; c < NUM_CRIT; c++)
    begin
      if (crit_active[c] && !crit_mask[crit_pos(c)])
      begin
        crit_any = 1'b1;
      end
    end
  end

  assign ctrl_o.standby       = state_reg.cfg1[CFG1_STBY_BIT];
  assign ctrl_o.timeout_en    = ~state_reg.cfg1[CFG1_TODIS_BIT];
  assign ctrl_o.fast_ch1      = state_reg.cfg1[CFG1_FAST_BIT];
  assign ctrl_o.res_cancel    = state_reg.cfg1[CFG1_RCAN_BIT];
  assign soft_reset_o         = soft_rst;
  assign reg_rdata_o          = state_reg.rdata;
  assign reg_rvalid_o         = state_reg.rvalid;
  assign alert_out_o          = 1'b0;
  assign alert_oe_o           = state_reg.alert;
  assign critical_temp_out_o  = 1'b0;
  assign critical_temp_oe_o   = crit_any;
endmodule : tmon_regs

// ### sim/tmon_regs_chk.sv
// port-level assertions for the temperature monitor register bank
`timescale 1ns/10ps
module tmon_regs_chk
  import tmon_pkg::*;
(
  input wire logic       clk_sys_i,
  input wire logic       rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       ara_ok_i,
  input wire logic       conv_done_i,
  input wire tmon_ctrl_t ctrl_o,
  input wire logic       soft_reset_o,
  input wire logic       alert_oe_o,
  input wire logic       critical_temp_oe_o
);
  logic wr1;
  assign wr1 = reg_wr_i && reg_addr_i == CMD_CFG1;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // ====================
  // a clean read: no write and no conversion beside it, so no set can win
  sequence s_rd(logic [7:0] a);
    reg_rd_i && !reg_wr_i && !conv_done_i && reg_addr_i == a;
  endsequence

  chk_ctrl_follow:
    assert property (wr1 && !reg_wdata_i[CFG1_SRST_BIT] |=> {ctrl_o.standby, 1'b0, !ctrl_o.timeout_en,
      ctrl_o.fast_ch1, ctrl_o.res_cancel, 3'h0} == ($past(reg_wdata_i) & CFG1_WMASK))
    else $error("control outputs differ from config");
  chk_soft_reset:
    assert property (wr1 && reg_wdata_i[CFG1_SRST_BIT] && !conv_done_i |-> soft_reset_o
      ##1 (ctrl_o == 4'h4 && !alert_oe_o && !critical_temp_oe_o))
    else $error("soft reset left state behind");
  chk_cfg_readback:
    assert property (reg_wr_i && reg_addr_i == CMD_CFG2 ##1 !reg_wr_i ##1 s_rd(CMD_CFG2)
      |=> reg_rdata_o == ($past(reg_wdata_i, 3) & CFG2_WMASK))
    else $error("config 2 readback wrong");
  chk_warn_clear:
    assert property (s_rd(CMD_STAT1) ##1 s_rd(CMD_STAT1) |=> reg_rdata_o == 8'h00)
    else $error("warning status not cleared by read");
  chk_alert_read:
    assert property (s_rd(CMD_STAT1) |=> !alert_oe_o)
    else $error("warning pin kept after status read");
  chk_alert_ara:
    assert property (ara_ok_i && !conv_done_i |=> !alert_oe_o)
    else $error("warning pin kept after alert response");
  chk_alert_cause:
    assert property ($rose(alert_oe_o) |-> $past(conv_done_i))
    else $error("warning pin rose without conversion");
  chk_crit_keep:
    assert property (s_rd(CMD_STAT2) ##0 critical_temp_oe_o |=> critical_temp_oe_o)
    else $error("critical pin dropped by status read");
  chk_late_ones:
    assert property (reg_rd_i && reg_addr_i == CMD_STAT3 && !$past(rst_i) |=> reg_rdata_o[6:5] == 2'b11)
    else $error("unused status 3 bits not set");
endmodule : tmon_regs_chk

bind tmon_regs tmon_regs_chk u_chk (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .ara_ok_i(ara_ok_i),
  .conv_done_i(conv_done_i), .ctrl_o(ctrl_o), .soft_reset_o(soft_reset_o), .alert_oe_o(alert_oe_o),
  .critical_temp_oe_o(critical_temp_oe_o)
);

// ### sim/tmon_host_model.sv
// host model issuing single-byte register reads and writes
`timescale 1ns/10ps
module tmon_host_model
  import tmon_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_rvalid_i,
  output logic      [7:0] reg_addr_o,
  output logic            reg_wr_o,
  output logic      [7:0] reg_wdata_o,
  output logic            reg_rd_o
);
  initial
    {reg_addr_o, reg_wr_o, reg_wdata_o, reg_rd_o} = '0;

  // ====================
  // released lines show inverted values so stale data never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    {reg_addr_o, reg_wdata_o, reg_wr_o} = {a, d, 1'b1};
    @(negedge clk_sys_i);
    {reg_addr_o, reg_wdata_o, reg_wr_o} = {~a, ~d, 1'b0};
  endtask : wr

  // n back-to-back reads; a missing valid pulse hands back unknowns
  task automatic rd(input logic [7:0] a, input int n, output logic [7:0] q);
    @(negedge clk_sys_i);
    {reg_addr_o, reg_rd_o} = {a, 1'b1};
    repeat (n) @(negedge clk_sys_i);
    {reg_addr_o, reg_rd_o} = {~a, 1'b0};
    q = reg_rvalid_i ? reg_rdata_i : 8'hXX;
  endtask : rd
endmodule : tmon_host_model

// ### sim/tmon_regs_tb_top.sv
// self-checking bench of the temperature monitor register bank
`timescale 1ns/10ps
module tmon_regs_tb_top
  import tmon_pkg::*;
;
  logic                           clk_sys_i = 1'b0;
  logic                           rst_i     = 1'b1;
  logic [7:0]                     addr, wdata, rdata, q, m, d, lim, e;
  logic                           wr, rd, rvalid, sr, a_out, a_oe, c_out, c_oe, h4, ara_ok, conv_done;
  logic [4:0]                     warn, w;
  logic [3:0]                     fault;
  tmon_crit_meas_t [NUM_CRIT-1:0] crit;
  tmon_ctrl_t                     ctrl;
  logic [31:0]                    lfsr = 32'hD5F7;
  logic [7:0]                     wm [3] = '{CFG1_WMASK, CFG2_WMASK, CFG3_WMASK};
  int                             mismatches = 0;
  int                             n_compared = 0;

  always #2 clk_sys_i = ~clk_sys_i;

  tmon_regs DUT (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .ara_ok_i(ara_ok), .conv_done_i(conv_done),
    .warn_exceed_i(warn), .crit_meas_i(crit), .diode_fault_i(fault), .ctrl_o(ctrl), .soft_reset_o(sr),
    .alert_out_o(a_out), .alert_oe_o(a_oe), .critical_temp_out_o(c_out), .critical_temp_oe_o(c_oe));
  tmon_host_model host (.clk_sys_i(clk_sys_i), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid),
    .reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wdata), .reg_rd_o(rd));

  // ====================
  // helpers
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  function automatic logic [7:0] exp_st1(input logic [4:0] x);
    return {1'b0, x[4], 2'b00, x[3:0]};
  endfunction : exp_st1
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic conv(input logic [4:0] x, input logic [31:0] c);
    @(negedge clk_sys_i);
    {warn, crit, conv_done} = {x, c, 1'b1};
    @(negedge clk_sys_i);
    {warn, crit, conv_done} = {~x, ~c, 1'b0};
  endtask : conv
  task automatic por_check;
    for (int a = 0; a < 7; a++)
    begin
      host.rd(a < 6 ? CMD_CFG1 + 8'(a) : 8'h07, 1, q);
      chk(q, a == 5 ? STAT3_LATE_ONE | {3'h0, fault, 1'b0} : REG_POR_VAL);
    end
  endtask : por_check
  task automatic stop_test;
    if (mismatches == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  initial
  begin
    // the whole sequence needs well under a thousand cycles
    repeat (5000) @(posedge clk_sys_i);
    mismatches++;
    stop_test();
  end

  // ====================
  // stimulus
  initial
  begin
    {ara_ok, conv_done, warn, fault, crit} = '0;
    repeat (12) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rst_i = 1'b0;
    chk({4'h0, ctrl}, 8'h04);
    por_check();
    for (int i = 0; i < 9; i++)
    begin
      lfsr = nxt(lfsr);
      d = (i % 3 == 0) ? lfsr[7:0] & 8'hBF : lfsr[7:0];
      host.wr(CMD_CFG1 + 8'(i % 3), d);
      host.rd(CMD_CFG1 + 8'(i % 3), 1, q);
      chk(q, d & wm[i % 3]);
      if (i % 3 == 0)
        chk({4'h0, ctrl}, {4'h0, d[7], ~d[5], d[4], d[3]});
      host.wr(CMD_STAT1 + 8'(i % 3), d);
    end
    for (int i = 0; i < 6; i++)
    begin
      lfsr = nxt(lfsr);
      m = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : lfsr[15:8];
      w = (i < 2) ? 5'h1F : lfsr[4:0];
      host.wr(CMD_CFG2, m);
      conv(w, 32'h0);
      chk({7'h0, a_oe}, {7'h0, |(exp_st1(w) & ~m)});
      if (i % 2)
      begin
        ara_ok = 1'b1;
        @(negedge clk_sys_i);
        ara_ok = 1'b0;
        chk({7'h0, a_oe}, 8'h00);
      end
      host.rd(CMD_STAT1, 1, q);
      chk(q, exp_st1(w));
      chk({7'h0, a_oe}, 8'h00);
      host.rd(CMD_STAT1, 2, q);
      chk(q, 8'h00);
    end
    // a conversion that lands on a status 1 read: the new set outlives the clear
    fork
      host.rd(CMD_STAT1, 1, q);
      conv(5'h01, 32'h0);
    join
    chk(q, 8'h00);
    chk({7'h0, a_oe}, {7'h0, ~m[0]});
    host.rd(CMD_STAT1, 1, q);
    chk(q, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      lfsr = nxt(lfsr);
      {h4, lim, m} = {lfsr[16], {1'b0, lfsr[14:8]} + 8'h08, lfsr[7:0] & CFG3_WMASK};
      host.wr(CMD_CFG3, m);
      conv(5'h00, {h4 ? lim + 8'h01 : lim - 8'h05, lim, lim + 8'h01, lim});
      e = {7'h0, ~m[0] | (h4 & ~m[3])};
      chk({7'h0, c_oe}, e);
      host.rd(CMD_STAT2, 1, q);
      chk(q, {4'h0, h4, 3'h1});
      host.rd(CMD_STAT2, 1, q);
      chk(q, 8'h00);
      conv(5'h00, {lim - HYST_DEG, lim, lim - HYST_DEG, lim});
      chk({7'h0, c_oe}, e);
      conv(5'h00, {lim - 8'h05, lim, lim - 8'h05, lim});
      chk({7'h0, c_oe}, 8'h00);
    end
    for (int i = 0; i < 3; i++)
    begin
      lfsr = nxt(lfsr);
      fault = (i == 0) ? 4'hF : lfsr[3:0];
      repeat (3) @(negedge clk_sys_i);
      host.rd(CMD_STAT3, 1, q);
      chk(q, STAT3_LATE_ONE | {3'h0, fault, 1'b0});
    end
    host.wr(CMD_CFG2, 8'h00);
    host.wr(CMD_CFG3, 8'h00);
    host.wr(CMD_CFG1, 8'h18);
    conv(5'h1F, {8'h90, 8'h10, 8'h90, 8'h10});
    chk({a_out, c_out, a_oe, c_oe, ctrl}, 8'h37);
    host.wr(CMD_CFG1, 8'hF8);
    chk({a_out, c_out, a_oe, c_oe, ctrl}, 8'h04);
    por_check();
    stop_test();
  end
endmodule : tmon_regs_tb_top
